// [p3io_pkg.sv]
// Constants for the port three and serial pin I/O block.
// Assumes a 100 MHz core clock and the core reset.
package p3io_pkg;
  // ****************************************
  // Widths, reset values and timing
  // ****************************************
  localparam int P3IO_WIDTH = 8;
  localparam logic [7:0] P3IO_LATCH_RESET = 8'hFF;
  localparam int P3IO_CLK_PERIOD_NS = 10;
  // Strong pull-up burst after a pin's drive value rises, in oscillator periods.
  localparam int P3IO_BOOST_PERIODS = 2;
  localparam logic [1:0] P3IO_BOOST_CYCLES = 2'(P3IO_BOOST_PERIODS);
  // Glitch rejection on the serial pins toward the I2C logic.
  localparam int P3IO_GLITCH_NS = 50;
  localparam int P3IO_GLITCH_CYCLES_INT = (P3IO_GLITCH_NS + P3IO_CLK_PERIOD_NS - 1) / P3IO_CLK_PERIOD_NS;
  localparam logic [3:0] P3IO_GLITCH_CYCLES = 4'(P3IO_GLITCH_CYCLES_INT);
  // Bit positions of the alternate functions.
  localparam int P3IO_BIT_RXD = 0;
  localparam int P3IO_BIT_TXD = 1;
  localparam int P3IO_BIT_IRQ0 = 2;
  localparam int P3IO_BIT_IRQ1 = 3;
  localparam int P3IO_BIT_TIMER0 = 4;
  localparam int P3IO_BIT_TIMER1 = 5;
  localparam int P3IO_BIT_WR = 6;
  localparam int P3IO_BIT_RD = 7;
endpackage : p3io_pkg

// [p3io_port.sv]
// Port three latch, pin drivers, alternate functions and serial pin I/O.
// Assumes pads resolve the drive, pull-up and sink enables; all pins are asynchronous.
`timescale 1ns/100ps

// Overview of operation
// - A latch bit at one leaves its pin only weakly pulled high so it can act as an input.
// - A latch bit at zero drives its pin low.
// - An alternate function reaches its pin only while the latch bit is one, else the pin is low.
// - Bits 0..3 carry serial receive, serial transmit, external interrupt 0 and 1.
// - Bits 4..7 carry timer 0 or PWM clock, timer 1, write strobe and read strobe.
// - With the serial select at zero the serial pins have only a weak pull-up.
// - With the serial select at one the SPI logic drives the serial pins push-pull.
// - Serial pin inputs toward the I2C logic reject glitches up to 50 ns.
// - In I2C master mode software drives the serial pins directly, usable as plain outputs.
// - The slave-select input always has a weak pull-up.
// - Ordinary reads return the pins; read-modify-write reads return the latch.
// - Bit operations read the whole latch, change one bit and write back the byte.
// - A pin's drive value (latch bit, ANDed with its alternate output on bits 1, 6, 7) rising from zero to one turns on the strong pull-up for two periods.
module p3io_port
  import p3io_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic wr_byte_i, // Core writes a whole byte.
  input wire logic wr_bit_i, // Core writes one bit.
  input wire logic [2:0] bit_sel_i, // Addressed bit for a bit write.
  input wire logic bit_val_i, // Value for a bit write.
  input wire logic [7:0] wdata_i, // Byte write data.
  input wire logic rd_latch_i, // Read-modify-write read selects the latch.
  output logic [7:0] rdata_o, // Read data.
  input wire logic [7:0] pin_i, // Port pin levels.
  output logic [7:0] pin_sink_o, // Pull-down enable per pin.
  output logic [7:0] pin_strong_o, // Strong pull-up enable per pin.
  output logic [7:0] pin_weak_o, // Weak holding pull-up enable per pin.
  input wire logic txd_i, // Serial transmit or shift clock.
  input wire logic wr_strobe_i, // Memory write strobe, low active level from core.
  input wire logic rd_strobe_i, // Memory read strobe.
  output logic rxd_o, // Serial receive data.
  output logic ext_irq0_pin_o, // External interrupt 0 level.
  output logic ext_irq1_pin_o, // External interrupt 1 level.
  output logic timer0_count_input_o, // Timer 0 count or PWM clock.
  output logic timer1_count_input_o, // Timer 1 count input.
  input wire logic serial_iface_select_i, // One for SPI, zero for I2C.
  input wire logic i2c_master_i, // I2C master mode gives software direct pin control.
  input wire logic [1:0] sw_serial_i, // Software levels for clock (0) and data (1).
  input wire logic [1:0] spi_out_i, // SPI drive for clock (0) and data (1).
  input wire logic [1:0] i2c_out_i, // I2C drive for clock (0) and data (1).
  input wire logic [1:0] serial_pin_i, // Clock and data pin levels.
  output logic [1:0] serial_sink_o, // Pull-down enable for serial pins.
  output logic [1:0] serial_strong_o, // Strong pull-up enable for serial pins.
  output logic [1:0] serial_weak_o, // Weak pull-up enable for serial pins.
  output logic [1:0] serial_spi_o, // Synchronised serial pin levels for SPI.
  output logic [1:0] serial_i2c_o, // Filtered serial pin levels for I2C.
  input wire logic slave_sel_n_i, // Slave-select pin level.
  output logic slave_sel_pullup_o, // Slave-select weak pull-up enable.
  output logic slave_sel_n_o // Synchronised slave-select level.
);

  // ****************************************
  // Latch and pin synchronisers
  // ****************************************
  logic [7:0] port_three_latch;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [1:0] ser_meta;
  logic [1:0] ser_sync;
  logic ss_meta;
  logic [7:0] drive_val;
  logic [7:0] next_latch;
  logic [7:0] prev_drive;
  logic [1:0] boost_cnt [8];
  logic [1:0] ser_val;
  logic [1:0] ser_filt;
  logic [3:0] filt_cnt [2];

  // Next latch value from byte or single-bit writes.
  always_comb begin
    next_latch = port_three_latch;
    if (wr_byte_i) begin
      next_latch = wdata_i;
    end else if (wr_bit_i) begin
      next_latch[bit_sel_i] = bit_val_i;
    end
  end

  // The latch itself.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_three_latch <= P3IO_LATCH_RESET;
    end else begin
      port_three_latch <= next_latch;
    end
  end

  // Two-flop synchronisers on every incoming pin.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 8'hFF;
      pin_sync <= 8'hFF;
      ser_meta <= 2'h3;
      ser_sync <= 2'h3;
      ss_meta <= 1'b1;
      slave_sel_n_o <= 1'b1;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
      ser_meta <= serial_pin_i;
      ser_sync <= ser_meta;
      ss_meta <= slave_sel_n_i;
      slave_sel_n_o <= ss_meta;
    end
  end

  // ****************************************
  // Core read path
  // ****************************************
  // Read-modify-write reads see the latch, others the pins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_latch_i ? port_three_latch : pin_sync;
    end
  end

  // ****************************************
  // Port pin drivers
  // ****************************************
  // Output functions are ANDed with the latch; input bits just hold the latch.
  always_comb begin
    drive_val = port_three_latch;
    drive_val[P3IO_BIT_TXD] = port_three_latch[P3IO_BIT_TXD] & txd_i;
    drive_val[P3IO_BIT_WR] = port_three_latch[P3IO_BIT_WR] & wr_strobe_i;
    drive_val[P3IO_BIT_RD] = port_three_latch[P3IO_BIT_RD] & rd_strobe_i;
  end

  // Per-bit strong pull-up burst on each rising drive value.
  for (genvar b = 0; b < P3IO_WIDTH; b++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        boost_cnt[b] <= 2'h0;
      end else if (drive_val[b] && !prev_drive[b]) begin
        boost_cnt[b] <= P3IO_BOOST_CYCLES;
      end else if (!drive_val[b]) begin
        boost_cnt[b] <= 2'h0;
      end else if (boost_cnt[b] != 2'h0) begin
        boost_cnt[b] <= boost_cnt[b] - 2'h1;
      end
    end
  end

  // Registered pad controls: low drives sink, high only pulls up.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_drive <= P3IO_LATCH_RESET;
      pin_sink_o <= 8'h00;
      pin_weak_o <= 8'hFF;
      pin_strong_o <= 8'h00;
    end else begin
      prev_drive <= drive_val;
      pin_sink_o <= ~drive_val;
      pin_weak_o <= drive_val;
      for (int i = 0; i < P3IO_WIDTH; i++) begin
        pin_strong_o[i] <= (drive_val[i] && !prev_drive[i]) || (boost_cnt[i] > 2'h1);
      end
    end
  end

  // Input alternate functions come from synchronised pins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_o <= 1'b1;
      ext_irq0_pin_o <= 1'b1;
      ext_irq1_pin_o <= 1'b1;
      timer0_count_input_o <= 1'b1;
      timer1_count_input_o <= 1'b1;
    end else begin
      rxd_o <= pin_sync[P3IO_BIT_RXD];
      ext_irq0_pin_o <= pin_sync[P3IO_BIT_IRQ0];
      ext_irq1_pin_o <= pin_sync[P3IO_BIT_IRQ1];
      timer0_count_input_o <= pin_sync[P3IO_BIT_TIMER0];
      timer1_count_input_o <= pin_sync[P3IO_BIT_TIMER1];
    end
  end

  // ****************************************
  // Serial clock and data pins
  // ****************************************
  // Drive source: SPI logic, software in I2C master mode, or I2C logic.
  always_comb begin
    if (serial_iface_select_i) begin
      ser_val = spi_out_i;
    end else if (i2c_master_i) begin
      ser_val = sw_serial_i;
    end else begin
      ser_val = i2c_out_i;
    end
  end

  // Pad controls for the serial pins and the slave-select pull-up.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_sink_o <= 2'h0;
      serial_strong_o <= 2'h0;
      serial_weak_o <= 2'h3;
      slave_sel_pullup_o <= 1'b1;
      serial_spi_o <= 2'h3;
    end else begin
      serial_sink_o <= ~ser_val;
      serial_weak_o <= ser_val;
      serial_strong_o <= serial_iface_select_i ? ser_val : 2'h0;
      slave_sel_pullup_o <= 1'b1;
      serial_spi_o <= ser_sync;
    end
  end

  // A level change passes to the I2C side only after it holds past the glitch time.
  for (genvar s = 0; s < 2; s++) begin : g_filt
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        filt_cnt[s] <= 4'h0;
        ser_filt[s] <= 1'b1;
      end else if (ser_sync[s] == ser_filt[s]) begin
        filt_cnt[s] <= 4'h0;
      end else if (filt_cnt[s] == P3IO_GLITCH_CYCLES) begin
        ser_filt[s] <= ser_sync[s];
        filt_cnt[s] <= 4'h0;
      end else begin
        filt_cnt[s] <= filt_cnt[s] + 4'h1;
      end
    end
  end
  assign serial_i2c_o = ser_filt;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  latch_low_sink_a: assert property (!port_three_latch[0] |=> pin_sink_o[0])
    else $error("Zero latch bit did not sink the pin.");
  alt_gate_a: assert property (!port_three_latch[P3IO_BIT_TXD] |=> pin_sink_o[P3IO_BIT_TXD])
    else $error("Alternate output passed a zero latch.");
  weak_high_a: assert property (drive_val[5] |=> pin_weak_o[5] && !pin_sink_o[5])
    else $error("High latch bit not weakly pulled up.");
  boost_len_a: assert property ($rose(drive_val[2]) ##1 drive_val[2] |-> pin_strong_o[2] ##1 pin_strong_o[2] ##1 !pin_strong_o[2])
    else $error("Strong pull-up burst length wrong.");
  i2c_no_strong_a: assert property (!serial_iface_select_i |=> serial_strong_o == 2'h0)
    else $error("Strong pull-up on in I2C mode.");
  spi_push_a: assert property (serial_iface_select_i |=> serial_strong_o == ~serial_sink_o)
    else $error("SPI pins not push-pull.");
  rmw_read_a: assert property (rd_latch_i |=> rdata_o == $past(port_three_latch))
    else $error("Latch read returned wrong value.");
  bit_write_a: assert property (wr_bit_i && !wr_byte_i |=> port_three_latch[$past(bit_sel_i)] == $past(bit_val_i))
    else $error("Bit write did not land.");
  glitch_rej_a: assert property (!((ser_sync[0] != ser_filt[0]) && (filt_cnt[0] == P3IO_GLITCH_CYCLES)) |=> $stable(ser_filt[0]))
    else $error("Glitch reached I2C side.");
  ss_pull_a: assert property (slave_sel_pullup_o)
    else $error("Slave-select pull-up off.");

  byte_write_c: cover property (wr_byte_i ##1 wr_bit_i);
  rise_boost_c: cover property ($rose(drive_val[0]));
  spi_mode_c: cover property (serial_iface_select_i ##1 !serial_iface_select_i);
  filt_pass_c: cover property ($changed(ser_filt[1]));

endmodule : p3io_port

// [p3io_pins_model.sv]
// Model of the outside world on a group of pins: pads, external pull-downs, floating lines.
// Assumes the pad enables come from the port block and the bench chooses the external drive.
`timescale 1ns/100ps
module p3io_pins_model #(
  parameter int W = 8
) (
  input wire logic clk_i, // Core clock, used only to vary a floating level.
  input wire logic [W-1:0] sink_i, // Pad pull-down enables.
  input wire logic [W-1:0] strong_i, // Pad strong pull-up enables.
  input wire logic [W-1:0] weak_i, // Pad weak pull-up enables.
  input wire logic [W-1:0] ext_low_i, // External device pulls the line low.
  output logic [W-1:0] pin_o // Resolved pin levels.
);
  logic flip = 1'b0;
  // A line nobody holds changes every cycle so that it never reads as a stable value.
  always_ff @(posedge clk_i) begin
    flip <= ~flip;
  end
  // Any pull-down beats the pull-ups, and a pull-up beats a floating line.
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (sink_i[k] || ext_low_i[k]) begin
        pin_o[k] = 1'b0;
      end else if (strong_i[k] || weak_i[k]) begin
        pin_o[k] = 1'b1;
      end else begin
        pin_o[k] = flip;
      end
    end
  end
endmodule : p3io_pins_model

// [p3io_port_tb.sv]
// Self-checking bench for the port three and serial pin block.
// Assumes pin models on both pin groups and the core driving the latch strobes.
`timescale 1ns/100ps
module p3io_port_tb;
  import p3io_pkg::*;
  logic clk_i = 0, rst_i = 1, wr_byte_i = 0, wr_bit_i = 0, bit_val_i = 0, rd_latch_i = 0;
  logic txd_i = 1, wr_strobe_i = 1, rd_strobe_i = 1, serial_iface_select_i = 0, i2c_master_i = 0;
  logic slave_sel_n_i = 1, rxd_o, ext_irq0_pin_o, ext_irq1_pin_o, timer0_count_input_o;
  logic timer1_count_input_o, slave_sel_pullup_o, slave_sel_n_o;
  logic [2:0] bit_sel_i = 0;
  logic [7:0] wdata_i = 0, ext_low = 0, rdata_o, pin_i, pin_sink_o, pin_strong_o, pin_weak_o;
  logic [1:0] sw_serial_i = 2'h3, spi_out_i = 2'h3, i2c_out_i = 2'h3, ser_low = 0, serial_pin_i;
  logic [1:0] serial_sink_o, serial_strong_o, serial_weak_o, serial_spi_o, serial_i2c_o;
  logic [7:0] alt_in;
  int err_count = 0, checks = 0;
  // Input alternate functions gathered into one byte for comparison.
  assign alt_in = {3'h0, timer1_count_input_o, timer0_count_input_o, ext_irq1_pin_o, ext_irq0_pin_o, rxd_o};
  // ****************************************
  // Design, pin models, clock and reset
  // ****************************************
  p3io_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_byte_i(wr_byte_i), .wr_bit_i(wr_bit_i),
    .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i), .wdata_i(wdata_i), .rd_latch_i(rd_latch_i),
    .rdata_o(rdata_o), .pin_i(pin_i), .pin_sink_o(pin_sink_o), .pin_strong_o(pin_strong_o),
    .pin_weak_o(pin_weak_o), .txd_i(txd_i), .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i),
    .rxd_o(rxd_o), .ext_irq0_pin_o(ext_irq0_pin_o), .ext_irq1_pin_o(ext_irq1_pin_o),
    .timer0_count_input_o(timer0_count_input_o), .timer1_count_input_o(timer1_count_input_o),
    .serial_iface_select_i(serial_iface_select_i), .i2c_master_i(i2c_master_i), .sw_serial_i(sw_serial_i),
    .spi_out_i(spi_out_i), .i2c_out_i(i2c_out_i), .serial_pin_i(serial_pin_i), .serial_sink_o(serial_sink_o),
    .serial_strong_o(serial_strong_o), .serial_weak_o(serial_weak_o), .serial_spi_o(serial_spi_o),
    .serial_i2c_o(serial_i2c_o), .slave_sel_n_i(slave_sel_n_i), .slave_sel_pullup_o(slave_sel_pullup_o),
    .slave_sel_n_o(slave_sel_n_o));
  p3io_pins_model #(.W(8)) u_pins (.clk_i(clk_i), .sink_i(pin_sink_o), .strong_i(pin_strong_o),
    .weak_i(pin_weak_o), .ext_low_i(ext_low), .pin_o(pin_i));
  p3io_pins_model #(.W(2)) u_ser (.clk_i(clk_i), .sink_i(serial_sink_o), .strong_i(serial_strong_o),
    .weak_i(serial_weak_o), .ext_low_i(ser_low), .pin_o(serial_pin_i));
  // The clock toggles every half period.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_byte(input logic [7:0] d);
    wr_byte_i = 1;
    wdata_i = d;
    step(1);
    wr_byte_i = 0;
  endtask : wr_byte
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_drive();
    chk("weak after reset", 8'h0_0FF, pin_weak_o);
    chk("sink after reset", 8'h0_000, pin_sink_o);
    wr_byte(8'h0_000);
    step(1);
    chk("sink at zero", 8'h0_0FF, pin_sink_o);
    wr_byte(8'h0_0FF);
    step(1);
    chk("strong first", 8'h0_0FF, pin_strong_o);
    step(1);
    chk("strong second", 8'h0_0FF, pin_strong_o);
    step(1);
    chk("strong off", 8'h0_000, pin_strong_o);
    chk("weak holds", 8'h0_0FF, pin_weak_o);
  endtask : t_drive
  task automatic t_rmw();
    wr_byte(8'h0_0A5);
    wr_bit_i = 1;
    bit_sel_i = 3;
    bit_val_i = 1;
    step(1);
    wr_bit_i = 0;
    rd_latch_i = 1;
    step(2);
    chk("latch read", 8'h0_0AD, rdata_o);
    ext_low = 8'h0_001;
    rd_latch_i = 0;
    step(5);
    chk("pin read", 8'h0_0AC, rdata_o);
    ext_low = 0;
  endtask : t_rmw
  task automatic t_alt();
    wr_byte(8'h0_0FF);
    {txd_i, wr_strobe_i, rd_strobe_i} = 3'h0;
    step(2);
    chk("alt outputs", 8'h0_0C2, pin_sink_o);
    {txd_i, wr_strobe_i, rd_strobe_i} = 3'h7;
    wr_byte(8'h0_0FD);
    step(2);
    chk("latch gates txd", 8'h0_002, pin_sink_o);
    wr_byte(8'h0_0FF);
    ext_low = 8'h0_03D;
    step(5);
    chk("alt inputs low", 8'h00, alt_in);
    ext_low = 0;
    wr_byte(8'h0_0FB);
    step(5);
    chk("alt inputs gated", 8'h1D, alt_in);
  endtask : t_alt
  task automatic t_serial();
    step(2);
    chk("i2c pads", 8'h0_003, {4'h0, serial_strong_o, serial_weak_o});
    serial_iface_select_i = 1;
    step(2);
    chk("spi high", 8'h0_00C, {4'h0, serial_strong_o, serial_sink_o});
    spi_out_i = 0;
    step(2);
    chk("spi low", 8'h0_003, {4'h0, serial_strong_o, serial_sink_o});
    serial_iface_select_i = 0;
    ser_low = 2'h1;
    step(4);
    ser_low = 0;
    for (int k = 0; k < 12; k++) begin
      step(1);
      chk("glitch rejected", 8'h0_003, {6'h0, serial_i2c_o});
    end
    ser_low = 2'h1;
    step(12);
    chk("long low", 8'h0_002, {6'h0, serial_i2c_o});
    chk("spi sync", 8'h02, {6'h0, serial_spi_o});
    ser_low = 0;
    i2c_master_i = 1;
    sw_serial_i = 2'h2;
    step(2);
    chk("software pins", 8'h0_001, {6'h0, serial_sink_o});
    slave_sel_n_i = 0;
    step(3);
    chk("select pull-up", 8'h0_002, {6'h0, slave_sel_pullup_o, slave_sel_n_o});
  endtask : t_serial
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // Main sequence: reset, then the scenarios in turn.
  initial begin
    step(4);
    rst_i = 0;
    step(1);
    t_drive();
    t_rmw();
    t_alt();
    t_serial();
    complete_run();
  end
  // Watchdog that ends a hung run well after the scenarios should have finished.
  initial begin
    #5000;
    err_count++;
    complete_run();
  end
endmodule : p3io_port_tb
